// ### hdl/acr_pkg.sv
// Package for the codec audio control register: address, fields, codes.
// Assumes a host write port of page, address and 16-bit data.
`default_nettype none

package acr_pkg;

  // ------------------------------------------------------------------
  // Location and reset
  // ------------------------------------------------------------------
  localparam logic [3:0] AUDIO_CONTROL_PAGE = 4'h2;
  localparam logic [5:0] AUDIO_CONTROL_ADDR = 6'h00;
  localparam logic [15:0] AUDIO_CONTROL_RESET = 16'hc003;

  // ------------------------------------------------------------------
  // Field positions (low bit of each field)
  // ------------------------------------------------------------------
  localparam int HPF_LSB = 14;
  localparam int LSRC_LSB = 12;
  localparam int RSRC_LSB = 10;
  localparam int GAIN_LSB = 8;
  localparam int MCLK_LSB = 6;
  localparam int RATE_LSB = 2;
  localparam int FMT_LSB = 0;

  // ------------------------------------------------------------------
  // Decoded settings
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    HPF_BYPASS, HPF_CORNER_0P1, HPF_CORNER_78U, HPF_CORNER_19U
  } acr_hpf_t;

  typedef enum logic [1:0] {
    SRC_MIC, SRC_LEFT_LINE, SRC_RIGHT_LINE, SRC_LINE_AVG
  } acr_src_t;

  typedef enum logic [1:0] {
    GAIN_0DB, GAIN_6DB, GAIN_12DB
  } acr_gain_t;

  typedef enum logic [1:0] {
    RATIO_256, RATIO_384, RATIO_512
  } acr_ratio_t;

  typedef enum logic [3:0] {
    FS_48K, FS_44K1, FS_32K, FS_24K, FS_22K05, FS_16K, FS_12K, FS_11K05,
    FS_8K, FS_INVALID
  } acr_rate_t;

  typedef enum logic [1:0] {
    JUST_RIGHT, JUST_LEFT, JUST_I2S
  } acr_just_t;

  // Word length in bits, justification per direction
  typedef struct packed {
    logic [4:0] playWidth;
    acr_just_t playJust;
    logic [4:0] recWidth;
    acr_just_t recJust;
  } acr_format_t;

  typedef struct packed {
    acr_hpf_t highpassCorner;
    acr_src_t leftRecordSource;
    acr_src_t rightRecordSource;
    acr_gain_t preampGain;
    acr_ratio_t masterClockRatio;
    logic [3:0] pllRateCode;
    acr_rate_t sampleRate;
    acr_format_t wordFormat;
  } acr_config_t;

  localparam logic [4:0] WIDTH_16 = 5'h10;
  localparam logic [4:0] WIDTH_20 = 5'h14;

endpackage : acr_pkg

`default_nettype wire

// ### hdl/acr_audio_control.sv
// Audio control register of the codec, with its decoded settings.
// Assumes the host write port is already in the sys_clk domain.
// Rate codes 9 to 15 are stored as written and flagged, never refused.
// Unmapped reads answer zero; a write wins over a read in one cycle.
//
// Contract
// R1 - 16-bit register at address 00h, page 2, fields MSB down to bit 0.
// R2 - Bits 15:14 pick high-pass: bypass, 0.1, 0.000078, 0.000019 Fs.
// R3 - Bits 13:12 route left record converter: mic, left, right, average.
// R4 - Bits 11:10 route right record converter with the same encoding.
// R5 - Bits 9:8 preamp gain: 00 and 01 0 dB, 10 6 dB, 11 12 dB.
// R6 - Bits 7:6 master clock ratio: 256, 384, 512, 256 again.
// R7 - Bits 5:2 sample-rate code passed straight to the clock PLL.
// R8 - Rate codes 0 to 8 decode 48 down to 8 kHz.
// R9 - Host never writes rate codes 1001 to 1111; the block stores and flags them, and the bench writes 1001.
// R10 - Format 00 16-bit right/left, 01 20-bit right/left, MSB first.
// R11 - Format 10 20-bit left both ways; 11 20-bit I2S, default.
// R12 - Reset value is 0xC003, all field defaults.
`default_nettype none

module acr_audio_control
  import acr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [3:0] hostPage,
  input wire logic [5:0] hostAddr,
  input wire logic [15:0] hostWriteData,
  output logic [15:0] hostReadData,
  output logic hostHit,
  output logic rateInvalid,
  output acr_config_t codecConfig
);

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  function automatic logic isOurs(input logic [3:0] page,
                                  input logic [5:0] addr);
    isOurs = (page == AUDIO_CONTROL_PAGE) &&
             (addr == AUDIO_CONTROL_ADDR); // see R1
  endfunction

  // Codes above 8 are undefined; flagged, never guessed
  function automatic acr_rate_t rateOf(input logic [3:0] code);
    case (code)
      4'h0: rateOf = FS_48K; // see R8
      4'h1: rateOf = FS_44K1; // see R8
      4'h2: rateOf = FS_32K; // see R8
      4'h3: rateOf = FS_24K; // see R8
      4'h4: rateOf = FS_22K05; // see R8
      4'h5: rateOf = FS_16K; // see R8
      4'h6: rateOf = FS_12K; // see R8
      4'h7: rateOf = FS_11K05; // see R8
      4'h8: rateOf = FS_8K; // see R8
      default: rateOf = FS_INVALID; // see R9
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Field decoders
  // ------------------------------------------------------------------
  // Corner or bypass straight from the two filter bits
  function automatic acr_hpf_t hpfOf(input logic [1:0] code);
    case (code)
      2'h0: hpfOf = HPF_BYPASS; // see R2
      2'h1: hpfOf = HPF_CORNER_0P1; // see R2
      2'h2: hpfOf = HPF_CORNER_78U; // see R2
      default: hpfOf = HPF_CORNER_19U; // see R2
    endcase
  endfunction

  // One encoding serves both record converters
  function automatic acr_src_t srcOf(input logic [1:0] code);
    case (code)
      2'h0: srcOf = SRC_MIC; // see R3 R4
      2'h1: srcOf = SRC_LEFT_LINE; // see R3 R4
      2'h2: srcOf = SRC_RIGHT_LINE; // see R3 R4
      default: srcOf = SRC_LINE_AVG; // see R3 R4
    endcase
  endfunction

  // Codes 00 and 01 both leave the preamp at unity
  function automatic acr_gain_t gainOf(input logic [1:0] code);
    case (code)
      2'h2: gainOf = GAIN_6DB; // see R5
      2'h3: gainOf = GAIN_12DB; // see R5
      default: gainOf = GAIN_0DB; // see R5
    endcase
  endfunction

  // Code 11 repeats the 256 ratio rather than adding a fourth
  function automatic acr_ratio_t ratioOf(input logic [1:0] code);
    case (code)
      2'h1: ratioOf = RATIO_384; // see R6
      2'h2: ratioOf = RATIO_512; // see R6
      default: ratioOf = RATIO_256; // see R6
    endcase
  endfunction

  // Named fields, so a reordered struct cannot swap play and record
  function automatic acr_format_t formatOf(input logic [1:0] code);
    acr_format_t fmt;
    fmt.playWidth = WIDTH_20;
    fmt.recWidth = WIDTH_20;
    fmt.playJust = JUST_I2S;
    fmt.recJust = JUST_I2S;
    case (code)
      2'h0: begin
        fmt.playWidth = WIDTH_16; // see R10
        fmt.recWidth = WIDTH_16; // see R10
        fmt.playJust = JUST_RIGHT; // see R10
        fmt.recJust = JUST_LEFT; // see R10
      end
      2'h1: begin
        fmt.playJust = JUST_RIGHT; // see R10
        fmt.recJust = JUST_LEFT; // see R10
      end
      2'h2: begin
        fmt.playJust = JUST_LEFT; // see R11
        fmt.recJust = JUST_LEFT; // see R11
      end
      default: begin
        fmt.playJust = JUST_I2S; // see R11
        fmt.recJust = JUST_I2S; // see R11
      end
    endcase
    return fmt;
  endfunction

  // One decoder for reset and run, so the two cannot drift apart
  function automatic acr_config_t decodeWord(input logic [15:0] word);
    acr_config_t cfg;
    cfg.highpassCorner = hpfOf(word[HPF_LSB +: 2]);
    cfg.leftRecordSource = srcOf(word[LSRC_LSB +: 2]); // see R3
    cfg.rightRecordSource = srcOf(word[RSRC_LSB +: 2]); // see R4
    cfg.preampGain = gainOf(word[GAIN_LSB +: 2]);
    cfg.masterClockRatio = ratioOf(word[MCLK_LSB +: 2]);
    cfg.pllRateCode = word[RATE_LSB +: 4]; // see R7
    cfg.sampleRate = rateOf(word[RATE_LSB +: 4]);
    cfg.wordFormat = formatOf(word[FMT_LSB +: 2]);
    return cfg;
  endfunction

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [15:0] audioControl;
  logic [15:0] next_audioControl;

  // Write takes effect on the edge the strobe is seen
  always_comb begin
    next_audioControl = audioControl;
    if (hostWrite && isOurs(hostPage, hostAddr)) begin
      next_audioControl = hostWriteData; // see R1
    end
  end

  // Reset loads the combined field defaults
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      audioControl <= AUDIO_CONTROL_RESET; // see R12
    end else begin
      audioControl <= next_audioControl;
    end
  end

  // ------------------------------------------------------------------
  // Host answer
  // ------------------------------------------------------------------
  logic [15:0] next_hostReadData;
  logic next_hostHit;

  // A write shuts out a read in the same cycle, so hit means one access
  always_comb begin
    next_hostReadData = hostReadData;
    next_hostHit = 1'b0;
    if (hostWrite) begin
      next_hostHit = isOurs(hostPage, hostAddr); // see R1
    end else if (hostRead) begin
      next_hostHit = isOurs(hostPage, hostAddr); // see R1
      if (isOurs(hostPage, hostAddr)) begin
        next_hostReadData = audioControl;
      end else begin
        next_hostReadData = 16'h0000; // Unmapped reads return zero
      end
    end
  end

  // Hit pulses one cycle; read data holds until the next read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hostReadData <= 16'h0000;
      hostHit <= 1'b0;
    end else begin
      hostReadData <= next_hostReadData;
      hostHit <= next_hostHit;
    end
  end

  // ------------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------------
  acr_config_t next_codecConfig;
  logic next_rateInvalid;
  logic [3:0] rateCode;

  assign rateCode = audioControl[RATE_LSB +: 4];

  // Decoded one cycle after the register, so outputs come from flops
  always_comb begin
    next_codecConfig = decodeWord(audioControl); // see R7
    next_rateInvalid = (rateOf(rateCode) == FS_INVALID); // see R9
  end

  // Reset codecConfig comes from the same decoder as the reset word; rateInvalid resets to 0
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      codecConfig <= decodeWord(AUDIO_CONTROL_RESET); // see R12
      rateInvalid <= 1'b0;
    end else begin
      codecConfig <= next_codecConfig;
      rateInvalid <= next_rateInvalid;
    end
  end

endmodule // acr_audio_control

`default_nettype wire

// ### dv/acr_audio_control_asserts.sv
// Port checker for the audio control register.
// Assumes one sys_clk domain and a bind onto acr_audio_control.
`default_nettype none
module acr_audio_control_asserts
  import acr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [3:0] hostPage,
  input wire logic [5:0] hostAddr,
  input wire logic [15:0] hostWriteData,
  input wire logic [15:0] hostReadData,
  input wire logic hostHit,
  input wire logic rateInvalid,
  input wire acr_config_t codecConfig
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------
  // Helpers: decode lags the strobe by two edges
  // --------------------------------------------------------------
  wire logic mapped = hostPage == AUDIO_CONTROL_PAGE &&
    hostAddr == AUDIO_CONTROL_ADDR;
  wire logic wr = hostWrite && mapped;
  logic [15:0] d1, d2;
  always_ff @(posedge sys_clk) begin
    d1 <= hostWriteData;
    d2 <= d1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  a_hit_taken: assert property ((hostWrite || hostRead)
    |=> hostHit == $past(mapped)) else $error("hit flag wrong");
  a_unmapped_zero: assert property (hostRead && !hostWrite
    && !mapped |=> hostReadData == 16'h0) else $error("unmapped read");
  a_hpf_field: assert property (wr |=> ##1
    codecConfig.highpassCorner == d2[15:14]) else $error("hpf field");
  a_source_fields: assert property (wr |=> ##1
    codecConfig.leftRecordSource == d2[13:12] &&
    codecConfig.rightRecordSource == d2[11:10]) else $error("source");
  a_gain_map: assert property (wr |=> ##1 codecConfig.preampGain ==
    (d2[9] ? {d2[8], ~d2[8]} : 2'h0)) else $error("gain map");
  a_ratio_map: assert property (wr |=> ##1
    codecConfig.masterClockRatio == (&d2[7:6] ? 2'h0 : d2[7:6]))
    else $error("ratio map");
  a_rate_code: assert property (wr |=> ##1
    codecConfig.pllRateCode == d2[5:2] && rateInvalid == (d2[5:2] > 4'h8))
    else $error("rate code");
  a_rate_decode: assert property (wr |=> ##1
    codecConfig.sampleRate == (d2[5:2] > 4'h8 ? 4'h9 : d2[5:2]))
    else $error("rate decode");
  a_format_width: assert property (wr |=> ##1
    codecConfig.wordFormat.playWidth ==
    (d2[1:0] == 2'h0 ? WIDTH_16 : WIDTH_20)) else $error("format width");
  a_reset_clear: assert property (disable iff (1'b0) srst |=>
    !hostHit && hostReadData == 16'h0 && codecConfig.sampleRate == FS_48K)
    else $error("reset state");
endmodule // acr_audio_control_asserts
bind acr_audio_control acr_audio_control_asserts
  acr_audio_control_asserts_inst (.sys_clk(sys_clk), .srst(srst),
  .hostWrite(hostWrite), .hostRead(hostRead), .hostPage(hostPage),
  .hostAddr(hostAddr), .hostWriteData(hostWriteData),
  .hostReadData(hostReadData), .hostHit(hostHit),
  .rateInvalid(rateInvalid), .codecConfig(codecConfig));
`default_nettype wire

// ### dv/acr_host_model.sv
// Host model driving the register write and read strobes.
// Assumes the block samples its port on the rising edge of sys_clk.
`default_nettype none
module acr_host_model (
  input wire logic sys_clk,
  output logic hostWrite,
  output logic hostRead,
  output logic [3:0] hostPage,
  output logic [5:0] hostAddr,
  output logic [15:0] hostWriteData
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------
  // Access tasks: one-cycle strobe, qualifiers scrambled after
  // --------------------------------------------------------------
  initial {hostWrite, hostRead, hostPage, hostAddr, hostWriteData} = '0;
  // Rate codes above 8 are sent only on purpose
  task automatic wr(input logic [3:0] p, input logic [5:0] a,
    input logic [15:0] d);
    @(posedge sys_clk);
    #2 {hostWrite, hostPage, hostAddr, hostWriteData} = {1'b1, p, a, d};
    @(posedge sys_clk);
    #2 {hostWrite, hostPage, hostAddr, hostWriteData} = {1'b0, ~p, ~a, ~d};
  endtask
  task automatic rd(input logic [3:0] p, input logic [5:0] a);
    @(posedge sys_clk);
    #2 {hostRead, hostPage, hostAddr} = {1'b1, p, a};
    @(posedge sys_clk);
    #2 {hostRead, hostPage, hostAddr} = {1'b0, ~p, ~a};
  endtask
endmodule // acr_host_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the audio control register.
// Assumes the host model is the only driver of the register port.
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  $display("wrong value %s exp %h seen %h", n, e, s); err_total++; end end
module tb_top
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic hostWrite, hostRead, hostHit, rateInvalid;
  logic [3:0] hostPage;
  logic [5:0] hostAddr;
  logic [15:0] hostWriteData, hostReadData;
  acr_config_t codecConfig;
  int err_total = 0;
  int comparisons = 0;
  always #12.5 sys_clk = ~sys_clk;
  acr_audio_control acr_audio_control_inst (.sys_clk(sys_clk), .srst(srst),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostPage(hostPage),
    .hostAddr(hostAddr), .hostWriteData(hostWriteData),
    .hostReadData(hostReadData), .hostHit(hostHit),
    .rateInvalid(rateInvalid), .codecConfig(codecConfig));
  acr_host_model acr_host_model_inst (.sys_clk(sys_clk),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostPage(hostPage),
    .hostAddr(hostAddr), .hostWriteData(hostWriteData));
  // --------------------------------------------------------------
  // Expected decode of a register word
  // --------------------------------------------------------------
  function automatic acr_config_t ecfg(input logic [15:0] d);
    acr_config_t c;
    c.highpassCorner = acr_hpf_t'(d[15:14]);
    c.leftRecordSource = acr_src_t'(d[13:12]);
    c.rightRecordSource = acr_src_t'(d[11:10]);
    c.preampGain = acr_gain_t'(d[9] ? {d[8], ~d[8]} : 2'h0);
    c.masterClockRatio = acr_ratio_t'(&d[7:6] ? 2'h0 : d[7:6]);
    c.pllRateCode = d[5:2];
    c.sampleRate = acr_rate_t'(d[5:2] > 4'h8 ? 4'h9 : d[5:2]);
    c.wordFormat.playWidth = d[1:0] == 2'h0 ? WIDTH_16 : WIDTH_20;
    c.wordFormat.recWidth = c.wordFormat.playWidth;
    c.wordFormat.playJust = &d[1:0] ? JUST_I2S :
      (d[1] ? JUST_LEFT : JUST_RIGHT);
    c.wordFormat.recJust = &d[1:0] ? JUST_I2S : JUST_LEFT;
    return c;
  endfunction
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic put(input logic [15:0] d);
    acr_host_model_inst.wr(AUDIO_CONTROL_PAGE, AUDIO_CONTROL_ADDR, d);
    `CHK("write hit", 1'b1, hostHit)
    @(posedge sys_clk);
    #2;
    `CHK("config", ecfg(d), codecConfig)
    `CHK("rate flag", d[5:2] > 4'h8, rateInvalid)
  endtask
  task automatic t_reset;
    `CHK("reset cfg", ecfg(AUDIO_CONTROL_RESET), codecConfig)
    acr_host_model_inst.rd(AUDIO_CONTROL_PAGE, AUDIO_CONTROL_ADDR);
    `CHK("reset read", AUDIO_CONTROL_RESET, hostReadData)
    `CHK("read hit", 1'b1, hostHit)
  endtask
  // Every code of every two-bit field, then readback
  task automatic t_fields;
    for (int k = 0; k < 4; k++) put({{5{k[1:0]}}, 2'h0, {2{k[1:0]}}});
    acr_host_model_inst.rd(AUDIO_CONTROL_PAGE, AUDIO_CONTROL_ADDR);
    `CHK("readback", 16'hffcf, hostReadData)
  endtask
  // Rates 0 to 8, and 9 sent on purpose to see it flagged
  task automatic t_rates;
    for (int r = 0; r < 10; r++) put({10'h300, r[3:0], 2'h3});
  endtask
  task automatic t_unmapped;
    acr_host_model_inst.wr(4'h3, AUDIO_CONTROL_ADDR, 16'h1234);
    `CHK("page miss", 1'b0, hostHit)
    acr_host_model_inst.wr(AUDIO_CONTROL_PAGE, 6'h01, 16'h1234);
    `CHK("addr miss", 1'b0, hostHit)
    acr_host_model_inst.rd(AUDIO_CONTROL_PAGE, AUDIO_CONTROL_ADDR);
    `CHK("kept", 16'hc027, hostReadData)
    acr_host_model_inst.rd(AUDIO_CONTROL_PAGE, 6'h01);
    `CHK("miss read", 16'h0, hostReadData)
  endtask
  // Reset in mid-run must bring the defaults back over a written word
  task automatic t_rereset;
    @(posedge sys_clk);
    #2 srst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #2 srst = 1'b0;
    t_reset();
  endtask
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence and watchdog sized far above the run length
  initial begin
    repeat (3) @(posedge sys_clk);
    #2 srst = 1'b0;
    t_reset();
    t_fields();
    t_rates();
    t_unmapped();
    t_rereset();
    stop_test();
  end
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
